// *** verilog/cmit_defs.svh ***
// Register offsets, field positions, reset values and divide masks of the interval timer
`ifndef CMIT_DEFS_SVH
`define CMIT_DEFS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define CMIT_OFS_START 8'h00
`define CMIT_OFS_CSR 8'h04
`define CMIT_OFS_CNT 8'h08
`define CMIT_OFS_COR 8'h0C
`define CMIT_OFS_STBY 8'h10
`define CMIT_OFS_ISTAT 8'h14
`define CMIT_OFS_IMASK 8'h18

// ****************************************************
// Field positions
// ****************************************************
`define CMIT_RUN_BIT 0
`define CMIT_STBY_BIT 0
`define CMIT_FLAG_BIT 7
`define CMIT_IRQEN_BIT 6
`define CMIT_CSEL_LO 0
`define CMIT_CSEL_HI 1
`define CMIT_EV_MATCH_BIT 0

// ****************************************************
// Reset values
// ****************************************************
`define CMIT_CNT_RST 16'h0000
`define CMIT_COR_RST 16'hFFFF
`define CMIT_STBY_RST 1'h1

// ****************************************************
// Prescaler divide masks (ratio minus one)
// ****************************************************
`define CMIT_DIV8_MASK 9'h007
`define CMIT_DIV32_MASK 9'h01F
`define CMIT_DIV128_MASK 9'h07F
`define CMIT_DIV512_MASK 9'h1FF

`endif

// *** verilog/cmit_pkg.sv ***
// Types and the shared divide-mask function of the interval timer
`include "cmit_defs.svh"

package cmit_pkg;

    // ****************************************************
    // Clock select codes
    // ****************************************************
    typedef enum logic [1:0] {
        CMIT_CSEL_DIV8 = 2'b00,
        CMIT_CSEL_DIV32 = 2'b01,
        CMIT_CSEL_DIV128 = 2'b10,
        CMIT_CSEL_DIV512 = 2'b11
    } cmit_csel_t;

    // ****************************************************
    // Register selection
    // ****************************************************
    typedef enum logic [2:0] {
        CMIT_SEL_START = 3'b000,
        CMIT_SEL_CSR = 3'b001,
        CMIT_SEL_CNT = 3'b010,
        CMIT_SEL_COR = 3'b011,
        CMIT_SEL_STBY = 3'b100,
        CMIT_SEL_ISTAT = 3'b101,
        CMIT_SEL_IMASK = 3'b110,
        CMIT_SEL_NONE = 3'b111
    } cmit_sel_t;

    function automatic logic [8:0] cmit_div_mask(input cmit_csel_t csel);
        case (csel)
            CMIT_CSEL_DIV8: cmit_div_mask = `CMIT_DIV8_MASK;
            CMIT_CSEL_DIV32: cmit_div_mask = `CMIT_DIV32_MASK;
            CMIT_CSEL_DIV128: cmit_div_mask = `CMIT_DIV128_MASK;
            default: cmit_div_mask = `CMIT_DIV512_MASK;
        endcase
    endfunction : cmit_div_mask

endpackage : cmit_pkg

// *** verilog/cmit_tick_if.sv ***
// Carrier between the timer core and its prescaler
interface cmit_tick_if;
    import cmit_pkg::*;
    logic run;
    cmit_csel_t csel;
    logic tick;
    modport timer (output run, output csel, input tick);
    modport prescaler (input run, input csel, output tick);
endinterface : cmit_tick_if

// *** verilog/cmit_prescaler.sv ***
// Prescaler that turns the peripheral clock into count-up enable pulses
module cmit_prescaler
    import cmit_pkg::*;
#(
    parameter int PRE_WIDTH = 9
) (
    input wire logic clk,
    input wire logic rst,
    cmit_tick_if.prescaler tk
);

    // ****************************************************
    // Parameter check
    // ****************************************************
    if (PRE_WIDTH != 9) begin : g_bad_width
        $error("cmit_prescaler: PRE_WIDTH must be 9");
    end

    logic [8:0] pre;
    logic [8:0] mask;

    assign mask = cmit_div_mask(tk.csel);

    // Restart from zero on start so the first tick comes one full period later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre <= 9'h000;
        end else if (tk.run) begin
            pre <= 9'(pre + 9'h001);
        end else begin
            pre <= 9'h000;
        end
    end

    // One-cycle enable per divided period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tk.tick <= 1'b0;
        end else begin
            tk.tick <= tk.run && ((pre & mask) == mask);
        end
    end

endmodule : cmit_prescaler

// *** verilog/cmit_timer.sv ***
// One channel of the 16-bit compare-match interval timer with APB register access
//
// Contract
// - With run bit set, counter increments once per selected clock tick.
// - Counter equal to compare constant: counter cleared, match flag set.
// - After a match clear, counting continues from zero untouched.
// - Counter clock is one of four divided peripheral clocks.
// - Match interrupt follows match flag AND enable one clock later.
// - Channel has its own match interrupt output.
// - Match fires on the tick after equality, as counter goes to zero.
// - Flag clears only by writing 0 after reading it as 1.
// - Comes up in standby, halted; registers locked until standby released.
// - Match clear in second bus cycle beats a counter write.
// - Word write to counter beats a coincident count-up tick.
// - Byte write beats count-up; other byte keeps its old value.
// - Equal counter and constant while stopped outside standby still sets flag and clears.
// - Select codes 00,01,10,11 divide by 8, 32, 128, 512.
// - Counter is a 16-bit read/write up-counter resetting to zero.
// - Compare constant is 16 bits, resets to all ones.
// - A new match between read and write keeps the flag set.
//
// The register addresses and the APB slave port are this design's own decisions.
`include "cmit_defs.svh"

module cmit_timer
    import cmit_pkg::*;
#(
    parameter int CNT_WIDTH = 16,
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic match_interrupt,
    output logic irq
);

    // ****************************************************
    // Parameter check
    // ****************************************************
    if (CNT_WIDTH != 16 || ADDR_WIDTH < 8) begin : g_bad_param
        $error("cmit_timer: CNT_WIDTH must be 16 and ADDR_WIDTH at least 8");
    end

    // ****************************************************
    // Functions
    // ****************************************************
    function automatic cmit_sel_t decode(input logic [7:0] a);
        if (a == `CMIT_OFS_START) begin
            decode = CMIT_SEL_START;
        end else if (a == `CMIT_OFS_CSR) begin
            decode = CMIT_SEL_CSR;
        end else if (a == `CMIT_OFS_CNT) begin
            decode = CMIT_SEL_CNT;
        end else if (a == `CMIT_OFS_COR) begin
            decode = CMIT_SEL_COR;
        end else if (a == `CMIT_OFS_STBY) begin
            decode = CMIT_SEL_STBY;
        end else if (a == `CMIT_OFS_ISTAT) begin
            decode = CMIT_SEL_ISTAT;
        end else if (a == `CMIT_OFS_IMASK) begin
            decode = CMIT_SEL_IMASK;
        end else begin
            decode = CMIT_SEL_NONE;
        end
    endfunction : decode

    // Byte-lane merge; an unwritten lane keeps its old contents
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] st
    );
        merge16[7:0] = st[0] ? wd[7:0] : old[7:0];
        merge16[15:8] = st[1] ? wd[15:8] : old[15:8];
    endfunction : merge16

    // Write or read strobe for one register
    function automatic logic reg_hit(
        input logic ev,
        input cmit_sel_t s,
        input cmit_sel_t want
    );
        reg_hit = ev && (s == want);
    endfunction : reg_hit

    // ****************************************************
    // Registers and wires
    // ****************************************************
    logic standby;
    logic channel_run_bit;
    logic match_flag;
    logic match_irq_enable;
    cmit_csel_t clock_select_field;
    logic [15:0] interval_counter;
    logic [15:0] compare_constant;
    logic flag_read_armed;
    logic irq_status;
    logic irq_mask;

    cmit_sel_t sel;
    logic locked;
    logic setup_ph;
    logic wr_ev;
    logic rd_ev;
    logic match_ev;
    logic cnt_wr;
    logic running;
    logic [31:0] next_prdata;
    logic [15:0] next_interval_counter;
    logic we_start;
    logic we_csr;
    logic we_cnt;
    logic we_cor;
    logic we_stby;
    logic we_istat;
    logic we_imask;
    logic re_csr;

    // Prescaler runs only while counting, so a stopped channel sees no ticks
    cmit_tick_if tk ();

    cmit_prescaler #(
        .PRE_WIDTH(9)
    ) u_prescaler (
        .clk(clk),
        .rst(rst),
        .tk(tk.prescaler)
    );

    // ****************************************************
    // Bus decode
    // ****************************************************
    assign sel = decode(paddr[7:0]);
    // Standby register stays reachable so software can wake the block
    assign locked = standby && (sel != CMIT_SEL_STBY);
    assign setup_ph = psel && !penable;
    assign wr_ev = psel && penable && pready && pwrite && !pslverr;
    assign rd_ev = psel && penable && pready && !pwrite && !pslverr;

    // ****************************************************
    // Register strobes
    // ****************************************************
    assign we_start = reg_hit(wr_ev, sel, CMIT_SEL_START);
    assign we_csr = reg_hit(wr_ev, sel, CMIT_SEL_CSR);
    assign we_cnt = reg_hit(wr_ev, sel, CMIT_SEL_CNT);
    assign we_cor = reg_hit(wr_ev, sel, CMIT_SEL_COR);
    assign we_stby = reg_hit(wr_ev, sel, CMIT_SEL_STBY);
    assign we_istat = reg_hit(wr_ev, sel, CMIT_SEL_ISTAT);
    assign we_imask = reg_hit(wr_ev, sel, CMIT_SEL_IMASK);
    assign re_csr = reg_hit(rd_ev, sel, CMIT_SEL_CSR);
    // A write with both counter lanes idle must not block the count-up
    assign cnt_wr = we_cnt && (pstrb[1:0] != 2'b00);

    // ****************************************************
    // Counting and match
    // ****************************************************
    assign running = channel_run_bit && !standby;
    assign tk.run = running;
    assign tk.csel = clock_select_field;

    // Running: compare only on a tick, so the match lands on the next tick
    // after equality. Stopped outside standby: an equal pair matches at once.
    always_comb begin
        if (standby) begin
            match_ev = 1'b0;
        end else if (running) begin
            match_ev = tk.tick && (interval_counter == compare_constant);
        end else begin
            match_ev = (interval_counter == compare_constant);
        end
    end

    // Priority: match clear, then bus write, then count-up
    always_comb begin
        next_interval_counter = interval_counter;
        if (match_ev) begin
            next_interval_counter = `CMIT_CNT_RST;
        end else if (cnt_wr) begin
            next_interval_counter = merge16(interval_counter, pwdata, pstrb);
        end else if (running && tk.tick) begin
            next_interval_counter = 16'(interval_counter + 16'h0001);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interval_counter <= `CMIT_CNT_RST;
        end else begin
            interval_counter <= next_interval_counter;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_constant <= `CMIT_COR_RST;
        end else if (we_cor) begin
            compare_constant <= merge16(compare_constant, pwdata, pstrb);
        end
    end

    // ****************************************************
    // Control registers
    // ****************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            standby <= `CMIT_STBY_RST;
        end else if (we_stby && pstrb[0]) begin
            standby <= pwdata[`CMIT_STBY_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_run_bit <= 1'b0;
        end else if (we_start && pstrb[0]) begin
            channel_run_bit <= pwdata[`CMIT_RUN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_irq_enable <= 1'b0;
        end else if (we_csr && pstrb[0]) begin
            match_irq_enable <= pwdata[`CMIT_IRQEN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_select_field <= CMIT_CSEL_DIV8;
        end else if (we_csr && pstrb[0]) begin
            clock_select_field <= cmit_csel_t'(pwdata[`CMIT_CSEL_HI:`CMIT_CSEL_LO]);
        end
    end

    // ****************************************************
    // Match flag with read-then-write clear
    // ****************************************************
    // Armed only by a read that returned 1; a fresh match disarms it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_read_armed <= 1'b0;
        end else if (match_ev) begin
            flag_read_armed <= 1'b0;
        end else if (re_csr) begin
            flag_read_armed <= prdata[`CMIT_FLAG_BIT];
        end else if (we_csr) begin
            flag_read_armed <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_flag <= 1'b0;
        end else if (match_ev) begin
            match_flag <= 1'b1;
        end else if (we_csr && pstrb[0] && flag_read_armed
                     && !pwdata[`CMIT_FLAG_BIT]) begin
            match_flag <= 1'b0;
        end
    end

    // ****************************************************
    // Interrupt status and mask
    // ****************************************************
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= 1'b0;
        end else if (match_ev) begin
            irq_status <= 1'b1;
        end else if (we_istat && pstrb[0]
                     && pwdata[`CMIT_EV_MATCH_BIT]) begin
            irq_status <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask <= 1'b0;
        end else if (we_imask && pstrb[0]) begin
            irq_mask <= pwdata[`CMIT_EV_MATCH_BIT];
        end
    end

    // Registered so both requests leave a flop; costs one clock of latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_interrupt <= 1'b0;
            irq <= 1'b0;
        end else begin
            match_interrupt <= match_flag && match_irq_enable;
            irq <= irq_status && irq_mask;
        end
    end

    // ****************************************************
    // Read data and bus answer
    // ****************************************************
    // Read data is captured in the setup cycle, giving zero wait states
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (!locked) begin
            case (sel)
                CMIT_SEL_START: next_prdata[`CMIT_RUN_BIT] = channel_run_bit;
                CMIT_SEL_CSR: begin
                    next_prdata[`CMIT_FLAG_BIT] = match_flag;
                    next_prdata[`CMIT_IRQEN_BIT] = match_irq_enable;
                    next_prdata[`CMIT_CSEL_HI:`CMIT_CSEL_LO] = clock_select_field;
                end
                CMIT_SEL_CNT: next_prdata[15:0] = interval_counter;
                CMIT_SEL_COR: next_prdata[15:0] = compare_constant;
                CMIT_SEL_STBY: next_prdata[`CMIT_STBY_BIT] = standby;
                CMIT_SEL_ISTAT: next_prdata[`CMIT_EV_MATCH_BIT] = irq_status;
                CMIT_SEL_IMASK: next_prdata[`CMIT_EV_MATCH_BIT] = irq_mask;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && (locked || sel == CMIT_SEL_NONE);
        end
    end

endmodule : cmit_timer

// *** bench/cmit_intc_model.sv ***
// Interrupt controller model that timestamps rising request edges
module cmit_intc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq,
    output int rises,
    output int stamp
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc;
    logic irq_d;
    // Edge stamps give exact periods, whatever the prescaler phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc <= 0;
            rises <= 0;
            stamp <= 0;
            irq_d <= 1'b0;
        end else begin
            cyc <= cyc + 1;
            irq_d <= irq;
            if (irq && !irq_d) begin
                rises <= rises + 1;
                stamp <= cyc;
            end
        end
    end
endmodule : cmit_intc_model

// *** bench/cmit_timer_checker.sv ***
// Port checker of the interval timer
`include "cmit_defs.svh"
module cmit_timer_checker #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic match_interrupt,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic stby;
    logic acc;
    logic wr_csr;
    logic wr_irq;
    assign acc = psel && penable && pwrite && pready;
    assign wr_csr = acc && paddr == `CMIT_OFS_CSR;
    assign wr_irq = acc && (paddr == `CMIT_OFS_ISTAT || paddr == `CMIT_OFS_IMASK);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stby <= 1'b1;
        end else if (acc && paddr == `CMIT_OFS_STBY && pstrb[0]) begin
            stby <= pwdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no ready after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_unmapped_err: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
        else $error("unmapped access accepted");
    a_standby_locks: assert property (
        psel && !penable && stby && paddr != `CMIT_OFS_STBY |=> pslverr)
        else $error("register reachable in standby");
    a_flag_irq_fall: assert property (
        $fell(match_interrupt) |-> $past(wr_csr, 1) || $past(wr_csr, 2))
        else $error("match interrupt dropped without a write");
    a_irq_fall_clear: assert property ($fell(irq) |-> $past(wr_irq, 1) || $past(wr_irq, 2))
        else $error("irq dropped without a write");
endmodule : cmit_timer_checker

bind cmit_timer cmit_timer_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_interrupt(match_interrupt), .irq(irq));

// *** bench/tb_top.sv ***
// Self-checking bench of the interval timer
`include "cmit_defs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst, psel, penable, pwrite, pready, pslverr, match_interrupt, irq, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb;
    logic [15:0] v;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int rises, stamp, t1, n;
    cmit_timer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .match_interrupt(match_interrupt), .irq(irq));
    cmit_intc_model u_intc (.clk(clk), .rst(rst), .irq(irq), .rises(rises), .stamp(stamp));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift
    function automatic int period(input int csel, input int cmp);
        return (cmp + 1) * (8 << (2 * csel));
    endfunction : period
    task conclude;
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // ****************************************************
    // Bus master
    // ****************************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No wait-state count assumed; only the bench timeout ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle keeps each strobe to one assignment per step
        @(posedge clk);
    endtask : apb
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wreg
    task automatic rreg(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 4'hF);
    endtask : rreg
    task automatic wait_rise(input int old);
        int k;
        k = 0;
        while (rises == old && k < 5000) begin
            @(posedge clk);
            k++;
        end
        `CHK(rises != old, 1'b1)
    endtask : wait_rise
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            conclude();
        end
    end
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        seed = 32'h191D;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rreg(`CMIT_OFS_CSR);
        `CHK({er, rd}, {1'b1, 32'h0})
        wreg(`CMIT_OFS_CNT, 32'h1234);
        rreg(`CMIT_OFS_STBY);
        `CHK(rd[0], 1'b1)
        wreg(`CMIT_OFS_STBY, 32'h0);
        rreg(`CMIT_OFS_CNT);
        `CHK({er, rd}, {1'b0, 32'h0})
        rreg(`CMIT_OFS_COR);
        `CHK(rd, 32'h0000FFFF)
        rreg(8'h1C);
        `CHK(er, 1'b1)
        wreg(`CMIT_OFS_IMASK, 32'h1);
        for (int csel = 0; csel < 4; csel++) begin
            seed = xorshift(seed);
            n = 1 + seed % 3;
            wreg(`CMIT_OFS_CNT, 32'h0);
            wreg(`CMIT_OFS_COR, n);
            wreg(`CMIT_OFS_CSR, csel);
            wreg(`CMIT_OFS_ISTAT, 32'h1);
            wreg(`CMIT_OFS_START, 32'h1);
            wait_rise(rises);
            t1 = stamp;
            wreg(`CMIT_OFS_ISTAT, 32'h1);
            wait_rise(rises);
            `CHK(stamp - t1, period(csel, n))
            rreg(`CMIT_OFS_CNT);
            `CHK(rd <= n, 1'b1)
            wreg(`CMIT_OFS_START, 32'h0);
        end
        wreg(`CMIT_OFS_COR, 32'hFFFF);
        wreg(`CMIT_OFS_CSR, 32'h0);
        rreg(`CMIT_OFS_CSR);
        `CHK(rd[7], 1'b1)
        wreg(`CMIT_OFS_CSR, 32'h0);
        rreg(`CMIT_OFS_CSR);
        `CHK(rd[7], 1'b0)
        wreg(`CMIT_OFS_CNT, 32'h5A00);
        apb(1'b1, `CMIT_OFS_CNT, 32'h0000FF3C, 4'h1);
        repeat (600) @(posedge clk);
        rreg(`CMIT_OFS_CNT);
        `CHK(rd, 32'h00005A3C)
        seed = xorshift(seed);
        // Zero would match every cycle once cleared and pin the flag high
        v = {1'b0, seed[14:1], 1'b1};
        wreg(`CMIT_OFS_CNT, v);
        wreg(`CMIT_OFS_COR, v);
        rreg(`CMIT_OFS_CNT);
        `CHK(rd, 32'h0)
        wreg(`CMIT_OFS_CSR, 32'h40);
        repeat (2) @(posedge clk);
        `CHK(match_interrupt, 1'b1)
        rreg(`CMIT_OFS_CSR);
        `CHK(rd[7:6], 2'b11)
        wreg(`CMIT_OFS_CSR, 32'h40);
        repeat (2) @(posedge clk);
        `CHK(match_interrupt, 1'b0)
        wreg(`CMIT_OFS_IMASK, 32'h0);
        rreg(`CMIT_OFS_ISTAT);
        `CHK({irq, rd[0]}, 2'b01)
        wreg(`CMIT_OFS_IMASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wreg(`CMIT_OFS_ISTAT, 32'h1);
        rreg(`CMIT_OFS_ISTAT);
        `CHK({irq, rd[0]}, 2'b00)
        conclude();
    end
endmodule : tb_top
